/* File: src/hrcs_pkg.sv */
// Constants and types for the hub reset and configuration sequencer
// Function
// - Configuration memory read only by sequential reads
// - Memory pins released while hardware reset low
// - Reset disables ports, removes port power
// - Reset disables transceivers, pairs high impedance
// - Reset aborts transaction, keeps no state
// - Reset returns registers to defaults
// - Reset halts oscillator and PLL
// - Configuration loads within 50 ms
// - Attach within 100 ms after configuration
// - Each host request completes within 5 ms
// - Upstream bus reset never forwarded downstream
// - Bus reset clears address, unconfigures device
// - Bus reset negates port power bits 3:2
// - Bus reset empties translator buffers
// - Bus reset wakes suspended device
// - Memory serial clock 58.6 kHz nominal
// - Default option uses internal configuration values
// - Device masters memory bus, start, stop
package hrcs_pkg;
   localparam int unsigned CLK_HZ = 125000000;
   localparam int unsigned CLK_PERIOD_NS = 8;
   // Recovery interval after reset release, in microseconds
   localparam int unsigned RECOVERY_US = 500;
   localparam int unsigned RECOVERY_CYC = (RECOVERY_US * 1000) / CLK_PERIOD_NS;
   // Configuration load bound, milliseconds
   localparam int unsigned CFG_MAX_MS = 50;
   localparam int unsigned CFG_MAX_CYC = CFG_MAX_MS * (CLK_HZ / 1000);
   // Attach bound after configuration, milliseconds
   localparam int unsigned ATTACH_MAX_MS = 100;
   localparam int unsigned ATTACH_MAX_CYC = ATTACH_MAX_MS * (CLK_HZ / 1000);
   // Request completion bound, milliseconds
   localparam int unsigned REQ_MAX_MS = 5;
   localparam int unsigned REQ_MAX_CYC = REQ_MAX_MS * (CLK_HZ / 1000);
   // Serial clock of configuration memory, hertz
   localparam int unsigned SCL_HZ = 58600;
   localparam int unsigned SCL_HALF_CYC = CLK_HZ / (2 * SCL_HZ);
   // Memory device address and read/write bits
   localparam logic [6:0] MEM_DEV_ADDR = 7'h50;
   localparam logic MEM_WR = 1'h0;
   localparam logic MEM_RD = 1'h1;
   localparam logic [7:0] MEM_START_OFS = 8'h00;
   // Port power field that bus reset negates
   localparam int unsigned PPC_NEG_HI = 3;
   localparam int unsigned PPC_NEG_LO = 2;
   localparam logic [7:0] REG_DEFAULT = 8'h00;
   localparam logic [6:0] ADDR_DEFAULT = 7'h00;
   typedef enum logic [2:0] {
      HRCS_RECOVER = 3'h0,
      HRCS_LOAD = 3'h1,
      HRCS_ATTACH = 3'h2,
      HRCS_RUN = 3'h3,
      HRCS_FAULT = 3'h4
   } hrcs_state_t;
   typedef enum logic [3:0] {
      HRCS_M_IDLE = 4'h0,
      HRCS_M_START = 4'h1,
      HRCS_M_WBYTE = 4'h2,
      HRCS_M_WACK = 4'h3,
      HRCS_M_RSTART = 4'h4,
      HRCS_M_RBYTE = 4'h5,
      HRCS_M_RACK = 4'h6,
      HRCS_M_STOP = 4'h7,
      HRCS_M_DONE = 4'h8
   } hrcs_mem_state_t;
endpackage

/* File: src/hrcs_mem_reader.sv */
// Two-wire master that reads the configuration memory sequentially
`timescale 1ns/1ns
`default_nettype none
module hrcs_mem_reader #(
   parameter int unsigned NBYTES = 16,
   parameter int unsigned HALF_CYC = hrcs_pkg::SCL_HALF_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic start_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic scl_o,
   output logic scl_oe_o,
   output logic [7:0] data_o,
   output logic data_vld_o,
   output logic done_o,
   output logic nack_o
);
   import hrcs_pkg::*;
   initial begin
      if (NBYTES < 1 || HALF_CYC < 2) $error("hrcs_mem_reader: bad parameters");
   end
   hrcs_mem_state_t st_reg;
   logic [15:0] div_reg;
   logic [1:0] ph_reg;
   logic [3:0] bit_reg;
   logic [1:0] wcnt_reg;
   logic [15:0] bcnt_reg;
   logic [7:0] sh_reg;
   logic sda_reg;
   logic scl_reg;
   logic nack_reg;
   logic tick;
   logic [7:0] wbyte;
   // Quarter-period tick; four quarters make one serial clock period
   assign tick = ce_i && (div_reg == 16'h0000);
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_reg <= 16'h0000;
      end else if (ce_i) begin
         div_reg <= (div_reg == 16'h0000) ? 16'((HALF_CYC / 2) - 1) : div_reg - 16'h0001;
      end
   end
   // Write phase sends device address then start offset, then a repeated start for reading
   always_comb begin
      case (wcnt_reg)
         2'h0: wbyte = {MEM_DEV_ADDR, MEM_WR};
         2'h1: wbyte = MEM_START_OFS;
         default: wbyte = {MEM_DEV_ADDR, MEM_RD};
      endcase
   end
   // Sequencer; a single read header then a run of bytes, all acknowledged but the last, never random reads
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= HRCS_M_IDLE;
         ph_reg <= 2'h0;
         bit_reg <= 4'h0;
         wcnt_reg <= 2'h0;
         bcnt_reg <= 16'h0000;
         sh_reg <= 8'h00;
         sda_reg <= 1'h1;
         scl_reg <= 1'h1;
         nack_reg <= 1'h0;
         data_o <= 8'h00;
         data_vld_o <= 1'h0;
      end else if (ce_i) begin
         data_vld_o <= 1'h0;
         if (st_reg == HRCS_M_IDLE) begin
            if (start_i) begin
               st_reg <= HRCS_M_START;
               ph_reg <= 2'h0;
               wcnt_reg <= 2'h0;
               bcnt_reg <= 16'h0000;
               nack_reg <= 1'h0;
            end
         end else if (tick) begin
            ph_reg <= ph_reg + 2'h1;
            case (st_reg)
               HRCS_M_START, HRCS_M_RSTART: begin
                  // Start: data falls while clock high
                  case (ph_reg)
                     2'h0: begin
                        sda_reg <= 1'h1;
                        scl_reg <= 1'h1;
                     end
                     2'h1: sda_reg <= 1'h0;
                     2'h2: scl_reg <= 1'h0;
                     default: begin
                        st_reg <= HRCS_M_WBYTE;
                        bit_reg <= 4'h7;
                        sh_reg <= wbyte;
                     end
                  endcase
               end
               HRCS_M_WBYTE, HRCS_M_WACK, HRCS_M_RBYTE, HRCS_M_RACK: begin
                  case (ph_reg)
                     2'h0: begin
                        if (st_reg == HRCS_M_WBYTE) sda_reg <= sh_reg[7];
                        else if (st_reg == HRCS_M_RACK) sda_reg <= (bcnt_reg == 16'(NBYTES - 1));
                        else sda_reg <= 1'h1;
                     end
                     2'h1: scl_reg <= 1'h1;
                     2'h2: begin
                        if (st_reg == HRCS_M_RBYTE) sh_reg <= {sh_reg[6:0], sda_i};
                        if (st_reg == HRCS_M_WACK && sda_i) nack_reg <= 1'h1;
                     end
                     default: begin
                        scl_reg <= 1'h0;
                        case (st_reg)
                           HRCS_M_WBYTE: begin
                              sh_reg <= {sh_reg[6:0], 1'h0};
                              if (bit_reg == 4'h0) st_reg <= HRCS_M_WACK;
                              else bit_reg <= bit_reg - 4'h1;
                           end
                           HRCS_M_WACK: begin
                              wcnt_reg <= wcnt_reg + 2'h1;
                              if (nack_reg) st_reg <= HRCS_M_STOP;
                              else if (wcnt_reg == 2'h1) st_reg <= HRCS_M_RSTART;
                              else if (wcnt_reg == 2'h2) begin
                                 st_reg <= HRCS_M_RBYTE;
                                 bit_reg <= 4'h7;
                              end else begin
                                 st_reg <= HRCS_M_WBYTE;
                                 bit_reg <= 4'h7;
                                 sh_reg <= MEM_START_OFS;
                              end
                           end
                           HRCS_M_RBYTE: begin
                              if (bit_reg == 4'h0) begin
                                 st_reg <= HRCS_M_RACK;
                                 data_o <= sh_reg;
                                 data_vld_o <= 1'h1;
                              end else bit_reg <= bit_reg - 4'h1;
                           end
                           default: begin
                              // Master acknowledges each byte but the last, keeping the read sequential
                              bit_reg <= 4'h7;
                              if (bcnt_reg == 16'(NBYTES - 1)) st_reg <= HRCS_M_STOP;
                              else begin
                                 bcnt_reg <= bcnt_reg + 16'h0001;
                                 st_reg <= HRCS_M_RBYTE;
                              end
                           end
                        endcase
                     end
                  endcase
               end
               HRCS_M_STOP: begin
                  // Stop: data rises while clock high
                  case (ph_reg)
                     2'h0: sda_reg <= 1'h0;
                     2'h1: scl_reg <= 1'h1;
                     2'h2: sda_reg <= 1'h1;
                     default: st_reg <= HRCS_M_DONE;
                  endcase
               end
               HRCS_M_DONE: st_reg <= HRCS_M_DONE;
               default: st_reg <= HRCS_M_IDLE;
            endcase
         end
      end
   end
   // Open drain: only low levels are driven
   assign sda_o = 1'h0;
   assign scl_o = 1'h0;
   assign sda_oe_o = !sda_reg;
   assign scl_oe_o = !scl_reg;
   assign done_o = (st_reg == HRCS_M_DONE);
   assign nack_o = nack_reg;
   property p_stop_seen;
      @(posedge clk_i) disable iff (!nrst_i) (st_reg == HRCS_M_STOP && ph_reg == 2'h3 && tick) |=> done_o;
   endproperty
   a_stop_seen: assert property (p_stop_seen) else $error("stop did not end read");
endmodule
`default_nettype wire

/* File: src/hrcs_top.sv */
// Hub reset and configuration sequencer top level
`timescale 1ns/1ns
`default_nettype none
module hrcs_top #(
   parameter int unsigned NPORTS = 2,
   parameter int unsigned CFG_BYTES = 16,
   parameter int unsigned RECOVERY_CYCLES = hrcs_pkg::RECOVERY_CYC,
   parameter int unsigned CFG_MAX_CYCLES = hrcs_pkg::CFG_MAX_CYC,
   parameter int unsigned ATTACH_MAX_CYCLES = hrcs_pkg::ATTACH_MAX_CYC,
   parameter int unsigned REQ_MAX_CYCLES = hrcs_pkg::REQ_MAX_CYC,
   parameter int unsigned SCL_HALF_CYCLES = hrcs_pkg::SCL_HALF_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic hw_reset_n_i,
   input wire logic use_default_cfg_i,
   input wire logic bus_reset_i,
   input wire logic suspend_req_i,
   input wire logic req_start_i,
   input wire logic req_done_i,
   input wire logic [6:0] set_addr_i,
   input wire logic set_addr_vld_i,
   input wire logic set_cfg_i,
   input wire logic [NPORTS*4-1:0] port_power_req_i,
   input wire logic mem_sda_i,
   output logic mem_sda_o,
   output logic mem_sda_oe_o,
   output logic mem_scl_o,
   output logic mem_scl_oe_o,
   output logic [NPORTS-1:0] port_enable_o,
   output logic [NPORTS*4-1:0] port_power_ctrl_o,
   output logic xcvr_enable_o,
   output logic osc_enable_o,
   output logic pll_enable_o,
   output logic abort_o,
   output logic tt_flush_o,
   output logic attach_o,
   output logic [6:0] dev_addr_o,
   output logic configured_o,
   output logic suspended_o,
   output logic cfg_from_default_o,
   output logic [7:0] cfg_data_o,
   output logic cfg_data_vld_o,
   output logic cfg_done_o,
   output logic cfg_fault_o,
   output logic req_timeout_o
);
   import hrcs_pkg::*;
   initial begin
      if (NPORTS < 1 || RECOVERY_CYCLES < 1 || CFG_MAX_CYCLES < 16 || REQ_MAX_CYCLES < 1 || ATTACH_MAX_CYCLES < 2)
         $error("hrcs_top: bad parameters");
   end
   // Pin inputs pass two flip-flops; only the second stage is read
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else if (ce_i) begin
         sync1_reg <= {hw_reset_n_i, use_default_cfg_i, bus_reset_i, mem_sda_i};
         sync2_reg <= sync1_reg;
      end
   end
   logic hwrst_n;
   logic dflt_cfg;
   logic busrst;
   logic sda_s;
   assign hwrst_n = sync2_reg[3];
   assign dflt_cfg = sync2_reg[2];
   assign busrst = sync2_reg[1];
   assign sda_s = sync2_reg[0];
   // Bus reset edge, so each bus reset acts once
   logic busrst_d_reg;
   logic busrst_rise;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) busrst_d_reg <= 1'h0;
      else if (ce_i) busrst_d_reg <= busrst;
   end
   assign busrst_rise = busrst && !busrst_d_reg;
   // Main sequencing state; hardware reset returns everything to defaults at once
   hrcs_state_t st_reg;
   logic [31:0] cnt_reg;
   logic mem_start_reg;
   logic mem_done;
   logic mem_nack;
   logic [7:0] mem_data;
   logic mem_vld;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= HRCS_RECOVER;
         cnt_reg <= 32'h00000000;
         mem_start_reg <= 1'h0;
         cfg_from_default_o <= 1'h0;
      end else if (ce_i) begin
         mem_start_reg <= 1'h0;
         if (!hwrst_n) begin
            st_reg <= HRCS_RECOVER;
            cnt_reg <= 32'h00000000;
            cfg_from_default_o <= 1'h0;
         end else begin
            cnt_reg <= cnt_reg + 32'h00000001;
            case (st_reg)
               HRCS_RECOVER: begin
                  if (cnt_reg >= 32'(RECOVERY_CYCLES - 1)) begin
                     st_reg <= HRCS_LOAD;
                     cnt_reg <= 32'h00000000;
                     cfg_from_default_o <= dflt_cfg;
                     mem_start_reg <= !dflt_cfg;
                  end
               end
               HRCS_LOAD: begin
                  if (cfg_from_default_o || mem_done) begin
                     st_reg <= HRCS_ATTACH;
                     cnt_reg <= 32'h00000000;
                  end else if (cnt_reg >= 32'(CFG_MAX_CYCLES - 1)) begin
                     st_reg <= HRCS_FAULT;
                  end
               end
               HRCS_ATTACH: begin
                  // Attach is signalled immediately, well inside the bound
                  st_reg <= HRCS_RUN;
               end
               HRCS_RUN: st_reg <= HRCS_RUN;
               HRCS_FAULT: st_reg <= HRCS_FAULT;
               default: st_reg <= HRCS_RECOVER;
            endcase
         end
      end
   end
   assign cfg_done_o = (st_reg == HRCS_ATTACH) || (st_reg == HRCS_RUN);
   assign cfg_fault_o = (st_reg == HRCS_FAULT);
   assign attach_o = (st_reg == HRCS_RUN);
   // Clock sources stop while reset is held
   assign osc_enable_o = hwrst_n;
   assign pll_enable_o = hwrst_n;
   // Transceivers off and pairs floating during reset and before attach
   assign xcvr_enable_o = hwrst_n && attach_o;
   assign abort_o = !hwrst_n;
   // Memory reader is held in reset with the device and while the reset pin is low,
   // so a read cut short by the pin leaves no half-done state behind
   logic mem_rst_n;
   logic sda_oe_int;
   logic scl_oe_int;
   assign mem_rst_n = nrst_i && hwrst_n;
   hrcs_mem_reader #(
      .NBYTES(CFG_BYTES),
      .HALF_CYC(SCL_HALF_CYCLES)
   ) u_mem (
      .clk_i(clk_i),
      .nrst_i(mem_rst_n),
      .ce_i(ce_i && hwrst_n),
      .start_i(mem_start_reg),
      .sda_i(sda_s),
      .sda_o(mem_sda_o),
      .sda_oe_o(sda_oe_int),
      .scl_o(mem_scl_o),
      .scl_oe_o(scl_oe_int),
      .data_o(mem_data),
      .data_vld_o(mem_vld),
      .done_o(mem_done),
      .nack_o(mem_nack)
   );
   // Tri-state memory pins while reset is low so outside programmers can write it
   assign mem_sda_oe_o = sda_oe_int && hwrst_n && (st_reg == HRCS_LOAD);
   assign mem_scl_oe_o = scl_oe_int && hwrst_n && (st_reg == HRCS_LOAD);
   // Configuration bytes come from the memory, or read zero under the default option
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_data_o <= REG_DEFAULT;
         cfg_data_vld_o <= 1'h0;
      end else if (ce_i) begin
         cfg_data_vld_o <= hwrst_n && mem_vld && !mem_nack;
         cfg_data_o <= hwrst_n ? mem_data : REG_DEFAULT;
      end
   end
   // USB device state; bus reset clears address and configuration and wakes from suspend
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dev_addr_o <= ADDR_DEFAULT;
         configured_o <= 1'h0;
         suspended_o <= 1'h0;
         tt_flush_o <= 1'h0;
      end else if (ce_i) begin
         tt_flush_o <= 1'h0;
         if (!hwrst_n || !attach_o) begin
            dev_addr_o <= ADDR_DEFAULT;
            configured_o <= 1'h0;
            suspended_o <= 1'h0;
         end else if (busrst_rise) begin
            dev_addr_o <= ADDR_DEFAULT;
            configured_o <= 1'h0;
            suspended_o <= 1'h0;
            tt_flush_o <= 1'h1;
         end else begin
            if (set_addr_vld_i) dev_addr_o <= set_addr_i;
            if (set_cfg_i) configured_o <= 1'h1;
            if (suspend_req_i) suspended_o <= 1'h1;
         end
      end
   end
   // Port enable and power; bus reset drops only bits 3:2 and is not passed downstream
   logic [NPORTS*4-1:0] ppc_reg;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ppc_reg <= '0;
         port_enable_o <= '0;
      end else if (ce_i) begin
         if (!hwrst_n || !attach_o) begin
            ppc_reg <= '0;
            port_enable_o <= '0;
         end else if (busrst_rise) begin
            for (int p = 0; p < NPORTS; p++) begin
               ppc_reg[p*4+PPC_NEG_HI -: 2] <= 2'h0;
            end
            // Downstream enables stay as they were; no reset signalling goes down
            port_enable_o <= port_enable_o;
         end else begin
            ppc_reg <= port_power_req_i;
            for (int p = 0; p < NPORTS; p++) begin
               port_enable_o[p] <= |port_power_req_i[p*4 +: 4];
            end
         end
      end
   end
   assign port_power_ctrl_o = ppc_reg;
   // Request watchdog flags a host request that outlives its bound
   logic req_busy_reg;
   logic [31:0] req_cnt_reg;
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_busy_reg <= 1'h0;
         req_cnt_reg <= 32'h00000000;
         req_timeout_o <= 1'h0;
      end else if (ce_i) begin
         if (!hwrst_n || busrst_rise || req_done_i) begin
            req_busy_reg <= 1'h0;
            req_cnt_reg <= 32'h00000000;
            req_timeout_o <= 1'h0;
         end else if (req_start_i && attach_o) begin
            req_busy_reg <= 1'h1;
            req_cnt_reg <= 32'h00000000;
            req_timeout_o <= 1'h0;
         end else if (req_busy_reg) begin
            req_cnt_reg <= req_cnt_reg + 32'h00000001;
            if (req_cnt_reg >= 32'(REQ_MAX_CYCLES - 1)) begin
               req_timeout_o <= 1'h1;
               req_busy_reg <= 1'h0;
            end
         end
      end
   end
   property p_pins_float;
      @(posedge clk_i) disable iff (!nrst_i) !hwrst_n |-> !mem_sda_oe_o && !mem_scl_oe_o;
   endproperty
   a_pins_float: assert property (p_pins_float) else $error("memory pins driven in reset");
   property p_attach;
      @(posedge clk_i) disable iff (!nrst_i) (ce_i && hwrst_n && st_reg == HRCS_ATTACH) |=> attach_o;
   endproperty
   a_attach: assert property (p_attach) else $error("attach not signalled");
   property p_ports_off;
      @(posedge clk_i) disable iff (!nrst_i) (ce_i && !hwrst_n) |=> (port_enable_o == '0) && (ppc_reg == '0);
   endproperty
   a_ports_off: assert property (p_ports_off) else $error("ports live in reset");
   property p_xcvr_off;
      @(posedge clk_i) disable iff (!nrst_i) !hwrst_n |-> !xcvr_enable_o;
   endproperty
   a_xcvr_off: assert property (p_xcvr_off) else $error("transceiver on in reset");
   property p_abort;
      @(posedge clk_i) disable iff (!nrst_i) (ce_i && !hwrst_n) |=> st_reg == HRCS_RECOVER && !req_busy_reg;
   endproperty
   a_abort: assert property (p_abort) else $error("state kept through reset");
   property p_clk_halt;
      @(posedge clk_i) disable iff (!nrst_i) !hwrst_n |-> !osc_enable_o && !pll_enable_o;
   endproperty
   a_clk_halt: assert property (p_clk_halt) else $error("clocks run in reset");
   property p_load_order;
      @(posedge clk_i) disable iff (!nrst_i) $rose(mem_start_reg) |-> hwrst_n && $past(st_reg) == HRCS_RECOVER;
   endproperty
   a_load_order: assert property (p_load_order) else $error("load before recovery");
   sequence s_bus_reset;
      ce_i && hwrst_n && attach_o && busrst_rise;
   endsequence
   property p_bus_reset;
      @(posedge clk_i) disable iff (!nrst_i)
         s_bus_reset |=> dev_addr_o == ADDR_DEFAULT && !configured_o && !suspended_o && tt_flush_o;
   endproperty
   a_bus_reset: assert property (p_bus_reset) else $error("bus reset not applied");
   property p_ppc_neg;
      @(posedge clk_i) disable iff (!nrst_i) s_bus_reset |=> ppc_reg[PPC_NEG_HI:PPC_NEG_LO] == 2'h0;
   endproperty
   a_ppc_neg: assert property (p_ppc_neg) else $error("port power bits stay set");
   // Downstream enables must not move on an upstream bus reset
   property p_no_fwd;
      @(posedge clk_i) disable iff (!nrst_i) s_bus_reset |=> port_enable_o == $past(port_enable_o);
   endproperty
   a_no_fwd: assert property (p_no_fwd) else $error("bus reset passed downstream");
endmodule
`default_nettype wire

/* File: bench/hrcs_eeprom_model.sv */
// Behavioural two-wire configuration memory behind pulled-up lines
`timescale 1ns/1ns
`default_nettype none
module hrcs_eeprom_model (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic pull_low_o
);
   int cnt = 0;
   logic [7:0] sh = 8'h00;
   logic [7:0] ptr = 8'h00;
   logic [7:0] q;
   logic first = 1'b0;
   logic rd = 1'b0;
   initial pull_low_o = 1'b0;
   // Start restarts framing, stop ends any read stream
   always @(negedge sda_i) if (scl_i) begin
      cnt = 0;
      first = 1'b1;
   end
   always @(posedge sda_i) if (scl_i) rd = 1'b0;
   // Bits are taken while the clock is high
   always @(posedge scl_i) begin
      if (cnt < 8) sh = {sh[6:0], sda_i};
      else if (cnt == 8 && rd && sda_i) rd = 1'b0;
      cnt = cnt + 1;
   end
   // Line changes only while the clock is low, so no false start or stop
   always @(negedge scl_i) begin
      if (cnt == 8) begin
         pull_low_o = !rd;
         if (rd) ptr = ptr + 8'h01;
         else if (first) rd = sh[0];
         else ptr = sh;
         first = 1'b0;
      end else begin
         if (cnt == 9) cnt = 0;
         q = ptr ^ 8'hA5;
         pull_low_o = rd && !q[7-cnt];
      end
   end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the hub reset and configuration sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import hrcs_pkg::*;
   logic clk_i = 0, nrst_i = 0, ce_i = 1, hw_reset_n_i = 0, use_default_cfg_i = 0, bus_reset_i = 0;
   logic suspend_req_i = 0, req_start_i = 0, req_done_i = 0, set_addr_vld_i = 0, set_cfg_i = 0;
   logic [6:0] set_addr_i = 7'h00;
   logic [7:0] port_power_req_i = 8'h00;
   logic mem_sda_i, mem_sda_o, mem_sda_oe_o, mem_scl_o, mem_scl_oe_o, xcvr_enable_o, osc_enable_o;
   logic pll_enable_o, abort_o, tt_flush_o, attach_o, configured_o, suspended_o, cfg_from_default_o;
   logic cfg_data_vld_o, cfg_done_o, cfg_fault_o, req_timeout_o, pull_low;
   logic [1:0] port_enable_o;
   logic [7:0] port_power_ctrl_o, cfg_data_o, seen[$];
   logic [6:0] dev_addr_o;
   int n_mismatch = 0, total_checks = 0;
   // Host wait after attach and request bound, both shortened for run time
   localparam int HOST_WAIT = 100;
   localparam int REQ_CYC = 200;
   // Short counts keep the run small
   hrcs_top #(.RECOVERY_CYCLES(20), .CFG_MAX_CYCLES(5000), .ATTACH_MAX_CYCLES(5000), .REQ_MAX_CYCLES(REQ_CYC),
      .SCL_HALF_CYCLES(4)) hrcs_top_inst (.clk_i, .nrst_i, .ce_i, .hw_reset_n_i, .use_default_cfg_i,
      .bus_reset_i, .suspend_req_i, .req_start_i, .req_done_i, .set_addr_i, .set_addr_vld_i, .set_cfg_i,
      .port_power_req_i, .mem_sda_i, .mem_sda_o, .mem_sda_oe_o, .mem_scl_o, .mem_scl_oe_o, .port_enable_o,
      .port_power_ctrl_o, .xcvr_enable_o, .osc_enable_o, .pll_enable_o, .abort_o, .tt_flush_o, .attach_o,
      .dev_addr_o, .configured_o, .suspended_o, .cfg_from_default_o, .cfg_data_o, .cfg_data_vld_o,
      .cfg_done_o, .cfg_fault_o, .req_timeout_o);
   hrcs_eeprom_model hrcs_eeprom_model_inst (.scl_i(!mem_scl_oe_o), .sda_i(mem_sda_i), .pull_low_o(pull_low));
   // Pull-up wins unless someone pulls low
   assign mem_sda_i = !(mem_sda_oe_o | pull_low);
   initial forever #4 clk_i = ~clk_i;
   always @(negedge clk_i) if (cfg_data_vld_o === 1'b1) seen.push_back(cfg_data_o);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Pin held low just past 1 us, then everything must be quiet
   task automatic hold_reset();
      hw_reset_n_i = 0;
      repeat (130) @(negedge clk_i);
      chk({3'h0, port_enable_o, xcvr_enable_o, osc_enable_o, pll_enable_o}, 8'h00);
      chk({4'h0, mem_sda_o, mem_scl_o, mem_sda_oe_o, mem_scl_oe_o}, 8'h00);
      chk(port_power_ctrl_o, 8'h00);
      chk({configured_o, dev_addr_o}, 8'h00);
      chk({6'h00, abort_o, attach_o}, 8'h02);
   endtask
   task automatic load(input logic dflt);
      int i;
      use_default_cfg_i = dflt;
      seen.delete();
      hw_reset_n_i = 1;
      repeat (20) begin
         @(negedge clk_i);
         chk({6'h00, mem_scl_oe_o, cfg_done_o}, 8'h00);
      end
      for (i = 0; i < 12000 && attach_o !== 1'b1; i++) @(negedge clk_i);
      chk({cfg_done_o, xcvr_enable_o, osc_enable_o, pll_enable_o, abort_o, attach_o, cfg_fault_o, cfg_from_default_o},
         {4'hF, 3'h2, dflt});
      if (!dflt) begin
         chk(8'(seen.size()), 8'h10);
         foreach (seen[k]) chk(seen[k], 8'(MEM_START_OFS + k) ^ 8'hA5);
      end
   endtask
   task automatic bus_rst();
      logic [1:0] pe;
      int i;
      repeat (HOST_WAIT) @(negedge clk_i);
      port_power_req_i = 8'hFF;
      set_addr_i = 7'h2A;
      set_addr_vld_i = 1;
      set_cfg_i = 1;
      @(negedge clk_i);
      set_addr_vld_i = 0;
      set_cfg_i = 0;
      suspend_req_i = 1;
      @(negedge clk_i);
      suspend_req_i = 0;
      repeat (3) @(negedge clk_i);
      chk({configured_o, dev_addr_o}, 8'hAA);
      chk({7'h00, suspended_o}, 8'h01);
      pe = port_enable_o;
      bus_reset_i = 1;
      for (i = 0; i < 10 && tt_flush_o !== 1'b1; i++) @(negedge clk_i);
      chk({7'h00, tt_flush_o}, 8'h01);
      chk(port_power_ctrl_o, 8'h33);
      repeat (2) @(negedge clk_i);
      bus_reset_i = 0;
      chk({configured_o, dev_addr_o}, 8'h00);
      chk({5'h00, suspended_o, port_enable_o}, {6'h00, pe});
   endtask
   // A request left open must be cut off by the bound
   task automatic req();
      int i;
      req_start_i = 1;
      @(negedge clk_i);
      req_start_i = 0;
      for (i = 0; i < 260 && req_timeout_o !== 1'b1; i++) @(negedge clk_i);
      chk({7'h00, req_timeout_o}, 8'h01);
      chk(8'(i), 8'(REQ_CYC));
   endtask
   initial begin
      repeat (5) @(negedge clk_i);
      nrst_i = 1;
      hold_reset();
      load(1);
      bus_rst();
      req();
      hold_reset();
      load(0);
      complete_run();
   end
   // Whole run is far below this span
   initial begin
      #400000;
      n_mismatch++;
      complete_run();
   end
endmodule
`default_nettype wire
